// [crc_link_pkg.sv]
// constants and types shared by the cyclic retransmission link logic
package crc_link_pkg;
	localparam int SEQ_W = 7;
	localparam int LI_W = 6;
	localparam int SIO_W = 8;
	localparam int OCT_W = 16;
	localparam logic [SEQ_W-1:0] FSN_RESET = 7'h7f;
	localparam logic [SEQ_W-1:0] SEQ_FULL = 7'h7f;
	localparam logic [LI_W-1:0] LI_FISU = 6'h00;
	localparam logic [LI_W-1:0] LI_LSSU = 6'h01;
	localparam logic [LI_W-1:0] LI_MSU_MIN = 6'h03;
	localparam logic INDICATOR_BIT = 1'b1;
	localparam logic [OCT_W-1:0] SIO_OCTETS = 16'h0001;
	localparam int N1_MAX = 127;
	localparam int N2_DEFAULT = 1024;
	localparam int FIFO_DEPTH = 8;
	localparam longint CLK_PERIOD_NS = 10;
	localparam longint T7_MS = 1000;
	localparam longint T7_CYCLES = (T7_MS * 1000000) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {su_fisu, su_lssu, su_msu} su_type_t;
	typedef enum logic {mode_cyclic, mode_forced} tx_mode_t;
endpackage : crc_link_pkg

// [su_fifo.sv]
// synchronous valid/ready fifo for new message units from level 3
`timescale 1ns/1ps
module su_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		$error("su_fifo depth must be a power of two, at least 2");
	if (WIDTH < 1)
		$error("su_fifo width must be positive");

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, next_wr_ptr;
	logic [AW-1:0] rd_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	// honest full and empty flags
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer and occupancy update
	always_comb begin
		next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
		next_count = count;
		if (push && !pop) begin
			next_count = (AW+1)'(count + 1'b1);
		end else if (pop && !push) begin
			next_count = (AW+1)'(count - 1'b1);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// storage, written only on an accepted push
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule : su_fifo

// [cyclic_retransmission_control.sv]
// level 2 error correction by preventive cyclic retransmission
//
// Functional notes
// - every sent message unit stays buffered until positively acknowledged
// - with nothing new waiting, unacknowledged buffered units are resent cyclically
// - with nothing to send or resend, fill-in units go out continuously
// - a new unit interrupts the retransmission cycle and goes first
// - new message unit gets previous sequence number plus one, modulo 128
// - non-message units carry sequence number of last sent message unit
// - sequence number not reused until it or later is acknowledged
// - forward and backward indicator bits are sent as 1
// - length indicator picks message units; status units passed on for processing
// - message unit repeating last accepted sequence number is discarded
// - message unit with next sequence number is accepted and delivered
// - any other sequence number is discarded, never delivered
// - acknowledgements processed for message and fill-in units unless unreasonable
// - sent backward number is last accepted sequence number, held till next
// - acknowledgement releases that unit and all earlier buffered units
// - repeated identical acknowledgement causes no further action
// - unreasonable acknowledgement discards that unit and the next one
// - two unreasonable of three consecutive units reports a faulty link
// - acknowledgement timer runs while units buffered; expiry reports failure
// - at count or octet limit, buffered units resent with priority in order
// - after a full forced pass, resume cyclic unless a limit still holds
// - message count limit never exceeds 127 buffered units
`timescale 1ns/1ps
module cyclic_retransmission_control
	import crc_link_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int N1_LIMIT = N1_MAX,
	parameter int N2_LIMIT = N2_DEFAULT,
	parameter longint T7_COUNT = T7_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [SIO_W-1:0] in_sio,
	input wire logic [LI_W-1:0] in_li,
	input wire logic [DATA_W-1:0] in_sif,
	input wire logic lssu_valid,
	output logic lssu_ready,
	input wire logic [SIO_W-1:0] lssu_status,
	output logic tx_valid,
	input wire logic tx_ready,
	output su_type_t tx_type,
	output logic [SEQ_W-1:0] tx_fsn,
	output logic [SEQ_W-1:0] tx_bsn,
	output logic tx_fib,
	output logic tx_bib,
	output logic [LI_W-1:0] tx_li,
	output logic [SIO_W-1:0] tx_sio,
	output logic [DATA_W-1:0] tx_sif,
	input wire logic rx_valid,
	input wire logic [SEQ_W-1:0] rx_fsn,
	input wire logic [SEQ_W-1:0] rx_bsn,
	input wire logic [LI_W-1:0] rx_li,
	input wire logic [SIO_W-1:0] rx_sio,
	input wire logic [DATA_W-1:0] rx_sif,
	output logic dlv_valid,
	output logic [LI_W-1:0] dlv_li,
	output logic [SIO_W-1:0] dlv_sio,
	output logic [DATA_W-1:0] dlv_sif,
	output logic other_valid,
	output logic [LI_W-1:0] other_li,
	output logic [SIO_W-1:0] other_status,
	output logic link_faulty,
	output logic ack_timeout,
	output logic [SEQ_W-1:0] n1_count,
	output logic forced_active
);
	localparam int EW = SIO_W + LI_W + DATA_W;
	if (N1_LIMIT < 1 || N1_LIMIT > N1_MAX)
		$error("message count limit must lie in 1..127");
	if (N2_LIMIT < 1 || N2_LIMIT >= (1 << OCT_W))
		$error("octet count limit out of range");
	if (T7_COUNT < 1 || T7_COUNT >= 64'h0000_0000_ffff_ffff)
		$error("acknowledgement timeout count out of range");
	localparam logic [SEQ_W-1:0] N1_LIM = SEQ_W'(N1_LIMIT);
	localparam logic [OCT_W-1:0] N2_LIM = OCT_W'(N2_LIMIT);
	localparam logic [31:0] T7_LIM = 32'(T7_COUNT);

	// new message units queue here; stalls push back to level 3
	logic q_valid, q_ready;
	logic [EW-1:0] q_data;
	su_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) new_queue (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data({in_sio, in_li, in_sif}),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data(q_data)
	);

	// retransmission buffer indexed by sequence number
	logic [EW-1:0] rt_mem [1 << SEQ_W];
	logic [OCT_W-1:0] cum_mem [1 << SEQ_W];

	// transmit state
	tx_mode_t mode, next_mode;
	logic [SEQ_W-1:0] fsn_last, next_fsn_last;
	logic [SEQ_W-1:0] rt_ptr, next_rt_ptr;
	logic [OCT_W-1:0] oct_total, next_oct_total;
	logic next_tx_valid;
	su_type_t next_tx_type;
	logic [SEQ_W-1:0] next_tx_fsn;
	logic [LI_W-1:0] next_tx_li;
	logic [SIO_W-1:0] next_tx_sio;
	logic [DATA_W-1:0] next_tx_sif;
	logic buf_we;

	// receive state
	logic [SEQ_W-1:0] ack_fsn, next_ack_fsn;
	logic [SEQ_W-1:0] rx_acc, next_rx_acc;
	logic [OCT_W-1:0] oct_base, next_oct_base;
	logic drop_next, next_drop_next;
	logic [2:0] hist, next_hist;
	logic [31:0] t7_cnt, next_t7_cnt;
	logic t7_fired, next_t7_fired;
	logic next_dlv_valid, next_other_valid;
	logic next_link_faulty, next_ack_timeout;
	logic [LI_W-1:0] next_dlv_li, next_other_li;
	logic [SIO_W-1:0] next_dlv_sio, next_other_status;
	logic [DATA_W-1:0] next_dlv_sif;

	// buffer occupancy in units and octets
	logic [SEQ_W-1:0] outstanding;
	logic [OCT_W-1:0] n2_count;
	logic at_limit, start_forced, rt_ok, cur_last;
	logic [SEQ_W-1:0] cur, ack_next;
	logic [EW-1:0] cur_entry;
	logic [SEQ_W-1:0] bsn_delta;
	logic unit_chk, unreason, released;

	assign outstanding = SEQ_W'(fsn_last - ack_fsn);
	assign n2_count = OCT_W'(oct_total - oct_base);
	assign n1_count = outstanding;
	assign at_limit = (outstanding >= N1_LIM) || (n2_count >= N2_LIM);
	assign ack_next = SEQ_W'(ack_fsn + 1'b1);
	assign rt_ok = (SEQ_W'(rt_ptr - ack_next) < outstanding);
	assign start_forced = (mode == mode_cyclic) && at_limit
		&& (outstanding != '0);
	assign cur = (rt_ok && !start_forced) ? rt_ptr : ack_next;
	assign cur_last = (cur == fsn_last);
	assign cur_entry = rt_mem[cur];
	assign forced_active = (mode == mode_forced);

	// new units are taken only in cyclic mode with a free number
	assign lssu_ready = tx_ready && (mode == mode_cyclic) && !start_forced;
	assign q_ready = lssu_ready && !lssu_valid
		&& (outstanding != SEQ_FULL);

	// transmit scheduler: picks the unit for the next link slot
	always_comb begin
		next_mode = mode;
		next_fsn_last = fsn_last;
		next_rt_ptr = rt_ptr;
		next_oct_total = oct_total;
		next_tx_valid = 1'b1;
		next_tx_type = tx_type;
		next_tx_fsn = tx_fsn;
		next_tx_li = tx_li;
		next_tx_sio = tx_sio;
		next_tx_sif = tx_sif;
		buf_we = 1'b0;
		if (tx_ready) begin
			// default slot is a fill-in unit carrying last sent number
			next_tx_type = su_fisu;
			next_tx_fsn = fsn_last;
			next_tx_li = LI_FISU;
			next_tx_sio = '0;
			next_tx_sif = '0;
			if (mode == mode_forced || start_forced) begin
				if (outstanding == '0) begin
					next_mode = mode_cyclic;
				end else begin
					// priority resend in original order
					next_tx_type = su_msu;
					next_tx_fsn = cur;
					{next_tx_sio, next_tx_li, next_tx_sif} = cur_entry;
					next_rt_ptr = cur_last ? ack_next : SEQ_W'(cur + 1'b1);
					next_mode = (cur_last && !at_limit) ?
						mode_cyclic : mode_forced;
				end
			end else if (lssu_valid) begin
				next_tx_type = su_lssu;
				next_tx_li = LI_LSSU;
				next_tx_sio = lssu_status;
			end else if (q_valid && outstanding != SEQ_FULL) begin
				// new message unit preempts the cycle
				next_fsn_last = SEQ_W'(fsn_last + 1'b1);
				next_tx_type = su_msu;
				next_tx_fsn = next_fsn_last;
				{next_tx_sio, next_tx_li, next_tx_sif} = q_data;
				next_oct_total = OCT_W'(oct_total + SIO_OCTETS
					+ OCT_W'(next_tx_li));
				buf_we = 1'b1;
			end else if (outstanding != '0) begin
				// cyclic resend of unacknowledged units
				next_tx_type = su_msu;
				next_tx_fsn = cur;
				{next_tx_sio, next_tx_li, next_tx_sif} = cur_entry;
				next_rt_ptr = cur_last ? ack_next : SEQ_W'(cur + 1'b1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mode <= mode_cyclic;
			fsn_last <= FSN_RESET;
			rt_ptr <= '0;
			oct_total <= '0;
			tx_valid <= 1'b0;
			tx_type <= su_fisu;
			tx_fsn <= FSN_RESET;
			tx_li <= LI_FISU;
			tx_sio <= '0;
			tx_sif <= '0;
		end else begin
			mode <= next_mode;
			fsn_last <= next_fsn_last;
			rt_ptr <= next_rt_ptr;
			oct_total <= next_oct_total;
			tx_valid <= next_tx_valid;
			tx_type <= next_tx_type;
			tx_fsn <= next_tx_fsn;
			tx_li <= next_tx_li;
			tx_sio <= next_tx_sio;
			tx_sif <= next_tx_sif;
		end
	end

	// buffered unit keeps its contents and running octet total
	always_ff @(posedge clock) begin
		if (buf_we) begin
			rt_mem[next_fsn_last] <= q_data;
			cum_mem[next_fsn_last] <= next_oct_total;
		end
	end

	// acknowledgement field and unused indicator bits
	assign tx_bsn = rx_acc;
	assign tx_fib = INDICATOR_BIT;
	assign tx_bib = INDICATOR_BIT;

	// received acknowledgement check against buffered numbers
	assign bsn_delta = SEQ_W'(rx_bsn - ack_fsn);
	assign unit_chk = rx_valid && (rx_li == LI_FISU || rx_li >= LI_MSU_MIN);
	assign unreason = bsn_delta > outstanding;
	assign released = unit_chk && !unreason && !drop_next
		&& (bsn_delta != '0);

	// receive side: sequence control, acknowledgements, supervision
	always_comb begin
		next_ack_fsn = ack_fsn;
		next_rx_acc = rx_acc;
		next_oct_base = oct_base;
		next_drop_next = drop_next;
		next_hist = hist;
		next_t7_cnt = t7_cnt;
		next_t7_fired = t7_fired;
		next_dlv_valid = 1'b0;
		next_dlv_li = dlv_li;
		next_dlv_sio = dlv_sio;
		next_dlv_sif = dlv_sif;
		next_other_valid = 1'b0;
		next_other_li = other_li;
		next_other_status = other_status;
		next_link_faulty = 1'b0;
		next_ack_timeout = 1'b0;
		if (rx_valid && !unit_chk) begin
			// status units go to the link state logic
			next_other_valid = 1'b1;
			next_other_li = rx_li;
			next_other_status = rx_sio;
		end
		if (unit_chk) begin
			next_hist = {hist[1:0], unreason};
			if ((next_hist[0] && next_hist[1]) || (next_hist[0] && next_hist[2])
				|| (next_hist[1] && next_hist[2])) begin
				next_link_faulty = 1'b1;
				next_hist = '0;
			end
			next_drop_next = unreason;
			if (released) begin
				next_ack_fsn = rx_bsn;
				next_oct_base = cum_mem[rx_bsn];
			end
			if (!unreason && !drop_next && rx_li >= LI_MSU_MIN
				&& rx_fsn == SEQ_W'(rx_acc + 1'b1)) begin
				// in sequence: accept and deliver
				next_rx_acc = rx_fsn;
				next_dlv_valid = 1'b1;
				next_dlv_li = rx_li;
				next_dlv_sio = rx_sio;
				next_dlv_sif = rx_sif;
			end // repeats and gaps fall through unused
		end
		// acknowledgement delay supervision
		if (released || outstanding == '0) begin
			next_t7_cnt = '0;
			next_t7_fired = 1'b0;
		end else if (!t7_fired) begin
			next_t7_cnt = 32'(t7_cnt + 1'b1);
			if (next_t7_cnt >= T7_LIM) begin
				next_ack_timeout = 1'b1;
				next_t7_fired = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ack_fsn <= FSN_RESET;
			rx_acc <= FSN_RESET;
			oct_base <= '0;
			drop_next <= 1'b0;
			hist <= '0;
			t7_cnt <= '0;
			t7_fired <= 1'b0;
			dlv_valid <= 1'b0;
			dlv_li <= '0;
			dlv_sio <= '0;
			dlv_sif <= '0;
			other_valid <= 1'b0;
			other_li <= '0;
			other_status <= '0;
			link_faulty <= 1'b0;
			ack_timeout <= 1'b0;
		end else begin
			ack_fsn <= next_ack_fsn;
			rx_acc <= next_rx_acc;
			oct_base <= next_oct_base;
			drop_next <= next_drop_next;
			hist <= next_hist;
			t7_cnt <= next_t7_cnt;
			t7_fired <= next_t7_fired;
			dlv_valid <= next_dlv_valid;
			dlv_li <= next_dlv_li;
			dlv_sio <= next_dlv_sio;
			dlv_sif <= next_dlv_sif;
			other_valid <= next_other_valid;
			other_li <= next_other_li;
			other_status <= next_other_status;
			link_faulty <= next_link_faulty;
			ack_timeout <= next_ack_timeout;
		end
	end
endmodule : cyclic_retransmission_control

// [crc_link_asserts.sv]
// assertion checker bound to the retransmission control ports
`timescale 1ns/1ps
module crc_link_asserts
	import crc_link_pkg::*;
#(
	parameter int N1_LIMIT = N1_MAX
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic lssu_ready,
	input wire su_type_t tx_type,
	input wire logic tx_fib,
	input wire logic tx_bib,
	input wire logic [SEQ_W-1:0] tx_bsn,
	input wire logic rx_valid,
	input wire logic [SEQ_W-1:0] rx_fsn,
	input wire logic [LI_W-1:0] rx_li,
	input wire logic [SIO_W-1:0] rx_sio,
	input wire logic dlv_valid,
	input wire logic [SIO_W-1:0] dlv_sio,
	input wire logic other_valid,
	input wire logic [LI_W-1:0] other_li,
	input wire logic [SIO_W-1:0] other_status,
	input wire logic link_faulty,
	input wire logic ack_timeout,
	input wire logic [SEQ_W-1:0] n1_count,
	input wire logic forced_active
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// received message units by their sequence number
	sequence s_msu_dup;
		rx_valid && rx_li >= LI_MSU_MIN && rx_fsn == tx_bsn;
	endsequence
	sequence s_msu_gap;
		rx_valid && rx_li >= LI_MSU_MIN && rx_fsn != tx_bsn + 7'h01;
	endsequence
	sequence s_quiet;
		!dlv_valid && !other_valid;
	endsequence
	a_dup_drop: assert property (s_msu_dup |=> !dlv_valid)
		else $error("repeated unit delivered");
	a_gap_drop: assert property (s_msu_gap |=> !dlv_valid)
		else $error("out of order unit delivered");
	a_fisu_quiet: assert property (
		rx_valid && rx_li == LI_FISU |=> s_quiet)
		else $error("fill-in unit passed upward");
	a_other_pass: assert property (
		rx_valid && (rx_li == LI_LSSU || rx_li == 6'h02)
		|=> other_valid && other_li == $past(rx_li))
		else $error("status unit not passed on");
	a_status_octet: assert property (
		other_valid |-> other_status == $past(rx_sio))
		else $error("status octet not passed on");
	a_dlv_octet: assert property (
		dlv_valid |-> dlv_sio == $past(rx_sio))
		else $error("delivered service octet differs");
	a_dlv_ack: assert property (
		dlv_valid |-> $past(rx_valid) && tx_bsn == $past(rx_fsn))
		else $error("acknowledge does not follow delivery");
	a_bsn_hold: assert property (!$stable(tx_bsn) |-> dlv_valid)
		else $error("acknowledge moved without delivery");
	a_ind_bits: assert property (tx_valid |-> tx_fib && tx_bib)
		else $error("indicator bit not one");
	a_n1_bound: assert property (n1_count <= N1_LIMIT)
		else $error("too many units buffered");
	a_forced_msu: assert property (
		forced_active |-> tx_type == su_msu)
		else $error("non message unit during forced pass");
	a_lssu_gate: assert property (
		lssu_ready |-> tx_ready && !forced_active)
		else $error("status unit taken while forced");
	a_fault_src: assert property (link_faulty |-> $past(rx_valid))
		else $error("fault without received unit");
	a_timer_busy: assert property (
		ack_timeout |-> $past(n1_count) != 7'h00)
		else $error("timeout with empty buffer");
endmodule : crc_link_asserts
bind cyclic_retransmission_control crc_link_asserts #(
	.N1_LIMIT(N1_LIMIT)
) chk_i (.*);

// [peer_link.sv]
// far-end terminal model: transmit slots and received units
`timescale 1ns/1ps
module peer_link
	import crc_link_pkg::*;
#(
	parameter int DATA_W = 32
) (
	input wire logic clock,
	input wire logic slow,
	output logic tx_ready,
	output logic rx_valid,
	output logic [SEQ_W-1:0] rx_fsn,
	output logic [SEQ_W-1:0] rx_bsn,
	output logic [LI_W-1:0] rx_li,
	output logic [SIO_W-1:0] rx_sio,
	output logic [DATA_W-1:0] rx_sif
);
	logic [SEQ_W*2+LI_W+DATA_W-1:0] q [$];
	logic [1:0] slot = 2'h0;
	// queue one unit toward the design
	function automatic void rx(input logic [SEQ_W-1:0] f,
		input logic [SEQ_W-1:0] b, input logic [LI_W-1:0] li,
		input logic [DATA_W-1:0] sif);
		q.push_back({f, b, li, sif});
	endfunction : rx
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_sio = 8'h00;
		{rx_fsn, rx_bsn, rx_li, rx_sif} = '0;
	end
	// slot every cycle, or one in four when slow; idle lines toggle
	always @(negedge clock) begin
		slot = slot + 2'h1;
		tx_ready = !slow || slot == 2'h0;
		rx_valid = q.size() != 0;
		rx_sio = ~rx_sio;
		if (rx_valid)
			{rx_fsn, rx_bsn, rx_li, rx_sif} = q.pop_front();
		else
			{rx_fsn, rx_bsn, rx_li, rx_sif} = ~{rx_fsn, rx_bsn, rx_li, rx_sif};
	end
endmodule : peer_link

// [testbench.sv]
// self-checking bench for the cyclic retransmission control
`timescale 1ns/1ps
module testbench;
	import crc_link_pkg::*;
	localparam int DW = 32;
	localparam int N1L = 6;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic in_valid = 1'b0;
	logic lssu_valid = 1'b0;
	logic slow = 1'b0;
	logic [SIO_W-1:0] in_sio = 8'h00;
	logic [SIO_W-1:0] lssu_status = 8'h00;
	logic [LI_W-1:0] in_li = 6'h03;
	logic [DW-1:0] in_sif = 32'h0;
	logic in_ready, lssu_ready, tx_valid, tx_ready, tx_fib, tx_bib;
	logic rx_valid, dlv_valid, other_valid, link_faulty, ack_timeout;
	logic forced_active;
	su_type_t tx_type;
	logic [SEQ_W-1:0] tx_fsn, tx_bsn, rx_fsn, rx_bsn, n1_count;
	logic [SEQ_W-1:0] nfsn = 7'h00;
	logic [SEQ_W-1:0] ack = 7'h7f;
	logic [SEQ_W-1:0] fsl [4] = '{7'h00, 7'h00, 7'h05, 7'h01};
	logic [LI_W-1:0] tx_li, rx_li, dlv_li, other_li, dli;
	logic [SIO_W-1:0] tx_sio, rx_sio, dlv_sio, other_status;
	logic [DW-1:0] tx_sif, rx_sif, dlv_sif, dsif;
	logic [DW-1:0] sent [128];
	logic [40:0] lg [$];
	int n_errors = 0;
	int checks = 0;
	int nd = 0, nf = 0, nt = 0, no = 0, cyc_n = 0, fi, k, b;
	always #5 clock = ~clock;
	cyclic_retransmission_control #(.DATA_W(DW), .N1_LIMIT(N1L),
		.T7_COUNT(50)) DUT (.*);
	peer_link #(.DATA_W(DW)) peer (.*);
	// log consumed units, count pulses, cut a hang short
	always @(posedge clock) begin
		cyc_n++;
		if (rst_n && tx_valid && tx_ready)
			lg.push_back({tx_type, tx_fsn, tx_sif});
		if (dlv_valid) begin
			dsif = dlv_sif;
			dli = dlv_li;
		end
		nd += int'(dlv_valid);
		nf += int'(link_faulty);
		nt += int'(ack_timeout);
		no += int'(other_valid);
		if (cyc_n == 20000) begin
			n_errors++;
			conclude();
		end
	end
	task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	// offer one random unit and hold it until taken
	task put;
		in_li = 6'(3 + $urandom % 20);
		in_sio = 8'($urandom);
		in_sif = $urandom;
		in_valid = 1'b1;
		while (in_ready !== 1'b1) @(negedge clock);
		sent[nfsn] = in_sif;
		nfsn++;
		@(negedge clock);
	endtask : put
	task puts(input int n);
		repeat (n) put();
		in_valid = 1'b0;
	endtask : puts
	// acknowledge everything buffered with a fill-in unit
	task ackall;
		ack = ack + n1_count;
		peer.rx(7'h00, ack, LI_FISU, 32'h0);
		cyc(4);
	endtask : ackall
	// expected successor of a resent unit in the cycle
	function automatic logic [SEQ_W-1:0] exp_next(
		input logic [SEQ_W-1:0] f, input logic [SEQ_W-1:0] last);
		return (f == last) ? SEQ_W'(ack + 7'h01) : SEQ_W'(f + 7'h01);
	endfunction : exp_next
	// check a captured run against the cyclic order
	task scan(input logic [SEQ_W-1:0] last);
		logic [SEQ_W-1:0] f, nx;
		fi = 0;
		nx = lg[0][38:32];
		foreach (lg[i]) begin
			f = lg[i][38:32];
			if (lg[i][40:39] == su_fisu)
				fi++;
			else begin
				chk(lg[i][31:0], sent[f]);
				chk(f, nx);
				nx = exp_next(f, last);
			end
		end
	endtask : scan
	task conclude;
		$display("checks %0d, errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	initial begin
		void'($urandom(32'hd1521884));
		cyc(16);
		rst_n = 1'b1;
		cyc(3);
		chk(tx_type, su_fisu);
		chk(tx_fsn, FSN_RESET);
		chk({tx_fib, tx_bib}, 2'h3);
		$display("reset test done");
		puts(4);
		cyc(20);
		lg = {};
		cyc(16);
		scan(7'h03);
		chk(fi, 0);
		chk(n1_count, 4);
		$display("cyclic test done");
		lg = {};
		puts(1);
		cyc(8);
		k = 0;
		while (k < 6 && lg[k][38:32] !== 7'h04) k++;
		chk(k < 5, 1);
		chk(lg[k][31:0], sent[4]);
		$display("priority test done");
		peer.rx(7'h00, 7'h02, LI_FISU, 32'h0);
		cyc(4);
		chk(n1_count, 2);
		peer.rx(7'h00, 7'h02, LI_FISU, 32'h0);
		peer.rx(7'h00, 7'h02, LI_FISU, 32'h0);
		cyc(4);
		chk(n1_count, 2);
		for (k = 0; k < 4; k++) peer.rx(fsl[k], 7'h03, 6'h05, 32'(k));
		peer.rx(7'h00, 7'h03, LI_LSSU, 32'h0);
		// the peer may start one cycle late, so leave room for the pulses
		cyc(8);
		chk(n1_count, 1);
		ack = 7'h03;
		chk(nd, 2);
		chk(tx_bsn, 1);
		chk(dsif, 3);
		chk(dli, 6'h05);
		chk(no, 1);
		chk(other_li, LI_LSSU);
		ackall();
		chk(n1_count, 0);
		lg = {};
		cyc(6);
		scan(7'h04);
		chk(fi, lg.size());
		chk(tx_fsn, 4);
		$display("receive test done");
		b = nd;
		peer.rx(7'h00, 7'h32, LI_FISU, 32'h0);
		peer.rx(7'h02, ack, 6'h05, 32'h0);
		repeat (3) peer.rx(7'h00, ack, LI_FISU, 32'h0);
		peer.rx(7'h02, ack, 6'h05, 32'h0);
		cyc(10);
		chk(nd, b + 1);
		chk(nf, 0);
		// sixth unit is a good one and is eaten by the last bad one
		for (k = 0; k < 6; k++)
			peer.rx(7'h00, k[0] ? ack : 7'h32, LI_FISU, 32'h0);
		cyc(8);
		chk(nf, 1);
		$display("fault test done");
		lssu_status = 8'($urandom);
		lssu_valid = 1'b1;
		while (lssu_ready !== 1'b1) @(negedge clock);
		@(negedge clock);
		lssu_valid = 1'b0;
		chk(tx_type, su_lssu);
		chk(tx_sio, lssu_status);
		chk(tx_li, LI_LSSU);
		$display("status test done");
		b = nt;
		puts(1);
		cyc(75);
		chk(nt - b, 1);
		ackall();
		$display("timer test done");
		slow = 1'b1;
		repeat (60) if (in_ready === 1'b1) put(); else cyc(1);
		in_valid = 1'b0;
		cyc(40);
		chk(in_ready, 0);
		chk(forced_active, 1);
		chk(n1_count, N1L);
		lg = {};
		cyc(60);
		scan(ack + 7'(N1L));
		chk(fi, 0);
		repeat (5) begin
			ackall();
			cyc(60);
		end
		chk(forced_active, 0);
		chk(in_ready, 1);
		chk(tx_fsn, nfsn - 7'h01);
		$display("forced test done");
		conclude();
	end
endmodule : testbench
